// >>> dbt_pkg.sv
// Package of register map, field layouts and reset values of the dual byte timer
package dbt_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] DBT_ADDR_CONTROL      = 16'hfe18;
	localparam logic [15:0] DBT_ADDR_PRESCALE_SEL = 16'hfe19;
	localparam logic [15:0] DBT_ADDR_LOW_COUNT    = 16'hfe1a;
	localparam logic [15:0] DBT_ADDR_HIGH_COUNT   = 16'hfe1b;
	localparam logic [15:0] DBT_ADDR_LOW_MATCH    = 16'hfe1c;
	localparam logic [15:0] DBT_ADDR_HIGH_MATCH   = 16'hfe1d;

	// ------------------------------------------------------------
	// Reset values and special data values
	// ------------------------------------------------------------
	localparam logic [7:0] DBT_CONTROL_RST   = 8'h00;
	localparam logic [7:0] DBT_PRESCALE_RST  = 8'h00;
	localparam logic [7:0] DBT_COUNT_RST     = 8'h00;
	localparam logic [7:0] DBT_MATCH_RST     = 8'h00;
	localparam logic [7:0] DBT_MATCH_ALL_ONE = 8'hff;
	localparam logic [7:0] DBT_COUNT_TOP     = 8'hff;
	localparam logic [7:0] DBT_READ_IDLE     = 8'h00;

	// ------------------------------------------------------------
	// Field layouts, most significant field first
	// ------------------------------------------------------------
	typedef struct packed {
		logic high_run;
		logic low_run;
		logic cascade_select;
		logic output_mode_select;
		logic high_match_flag;
		logic high_irq_enable;
		logic low_match_flag;
		logic low_irq_enable;
	} dbt_ctrl_t;

	typedef struct packed {
		logic       high_prescale_enable;
		logic [2:0] high_prescale_code;
		logic       low_prescale_enable;
		logic [2:0] low_prescale_code;
	} dbt_presc_t;

	// Events of one timer half, all one-cycle pulses
	typedef struct packed {
		logic match_hit;
		logic overflow_hit;
		logic reach_zero;
	} dbt_events_t;

endpackage

// >>> dbt_timer.sv
// Dual byte timer with prescalers, double-buffered match and toggle/PWM out
`timescale 1ns/1ps
// Functional notes
// - High run 0 holds high counter at 0, buffer follows match; 1 counts.
// - Low run 0 holds low counter at 0, buffer follows match; 1 counts.
// - Cascade 0: two 8-bit timers; 1: high advances once per low period.
// - Each half makes its own match signal, regardless of cascade select.
// - Modes 0,2 toggle both; mode 1 PWM both; mode 3 high toggle, low PWM.
// - PWM period is 256 count clocks times that half's prescaler count.
// - Mode 3 high toggle period 2*(hmatch+1)*hpresc*256*lpresc cycles.
// - High match flag sets when running high counter reaches 0; software clears.
// - Interrupt request while high irq enable and high match flag are 1.
// - Low match flag sets when running low counter reaches 0; software clears.
// - Interrupt request while low irq enable and low match flag are 1.
// - Prescaler setting written while running applies at match buffer reload.
// - High prescaler divides by 1, or by 2^(code+1) when enabled.
// - Low prescaler divides by 1, or by 2^(code+1) when enabled.
// - Low counter is read-only and counts low prescaler pulses.
// - High counter is read-only and counts high prescaler pulses.
// - Each half has an 8-bit match buffer compared against its counter.
// - Low buffer follows register when stopped, reloads at counter zero running.
// - High buffer follows register when stopped, reloads at counter zero running.
// - Low output toggles on match, or clears on overflow and sets on match.
// - High output PWM only in mode 1, otherwise toggles on high match.
// - Output high while stopped; low while running with match register FFH.
// - Counter resets on match: low in modes 0,2; high in modes 0,2,3.

// ------------------------------------------------------------
// One timer half: prescaler, counter, match buffer and output
// ------------------------------------------------------------
module dbt_half
	import dbt_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic        base_tick,
	input  wire logic        presc_enable,
	input  wire logic [2:0]  presc_code,
	input  wire logic [7:0]  match_reg,
	input  wire logic        reset_on_match,
	input  wire logic        pwm_mode,
	output logic      [7:0]  count,
	output dbt_events_t      events,
	output logic             wave
);
	logic [7:0] pcnt_q;
	logic [7:0] pcnt_d;
	logic [7:0] limit_q;
	logic [7:0] limit_d;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] buf_q;
	logic [7:0] buf_d;
	logic       wave_q;
	logic       wave_d;
	logic [7:0] limit_new;
	logic       presc_hit;
	logic       match_hit;
	logic       ovf_hit;
	logic       reach_zero;
	logic       wave_run;

	// Terminal count of the prescaler: divide by 1 or by 2^(code+1)
	assign limit_new = presc_enable ?
		8'((9'h002 << presc_code) - 9'h001) : 8'h00;

	assign presc_hit  = run && base_tick && (pcnt_q == limit_q);
	assign match_hit  = presc_hit && (cnt_q == buf_q);
	assign ovf_hit    = presc_hit && (cnt_q == DBT_COUNT_TOP);
	assign reach_zero = presc_hit && (cnt_d == DBT_COUNT_RST);

	assign pcnt_d = !run ? 8'h00 :
		(base_tick ? (presc_hit ? 8'h00 : 8'(pcnt_q + 8'h01)) : pcnt_q);

	// Stopped counter sits at zero; a match may restart the count
	assign cnt_d = !run ? DBT_COUNT_RST :
		(!presc_hit ? cnt_q :
		((match_hit && reset_on_match) ? DBT_COUNT_RST :
		8'(cnt_q + 8'h01)));

	// Buffer and prescaler setting swap together so a period never mixes
	assign buf_d = (!run || reach_zero) ? match_reg : buf_q;
	assign limit_d = (!run || reach_zero) ? limit_new : limit_q;

	// PWM clears on overflow and sets on match; toggle flips on match
	assign wave_run = pwm_mode ?
		(match_hit ? 1'b1 : (ovf_hit ? 1'b0 : wave_q)) :
		(match_hit ? ~wave_q : wave_q);
	assign wave_d = !run ? 1'b1 :
		((match_reg == DBT_MATCH_ALL_ONE) ? 1'b0 : wave_run);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pcnt_q  <= 8'h00;
			limit_q <= 8'h00;
			cnt_q   <= DBT_COUNT_RST;
			buf_q   <= DBT_MATCH_RST;
			wave_q  <= 1'b1;
		end
		else
		begin
			pcnt_q  <= pcnt_d;
			limit_q <= limit_d;
			cnt_q   <= cnt_d;
			buf_q   <= buf_d;
			wave_q  <= wave_d;
		end
	end

	assign count               = cnt_q;
	assign wave                = wave_q;
	assign events.match_hit    = match_hit;
	assign events.overflow_hit = ovf_hit;
	assign events.reach_zero   = reach_zero;
endmodule

// ------------------------------------------------------------
// Top: register port, mode decode, clock bases and flags
// ------------------------------------------------------------
module dbt_timer
	import dbt_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [7:0]  rd_data,
	input  wire logic        event_in,
	input  wire logic        low_event_sel,
	output logic             high_output,
	output logic             low_output,
	output logic             irq_req
);
	dbt_ctrl_t   ctrl_q;
	dbt_ctrl_t   ctrl_d;
	dbt_presc_t  presc_q;
	logic [7:0]  low_match_q;
	logic [7:0]  high_match_q;
	logic [7:0]  rd_data_q;
	logic [7:0]  rd_mux;
	logic        half_tick_q;
	logic        ev_s1_q;
	logic        ev_s2_q;
	logic        ev_s3_q;
	logic        event_pulse;
	logic [7:0]  low_count;
	logic [7:0]  high_count;
	dbt_events_t low_ev;
	dbt_events_t high_ev;
	logic        low_base;
	logic        high_base;
	logic        wr_ctrl;
	logic        wr_presc;
	logic        wr_lmatch;
	logic        wr_hmatch;
	logic        low_rst_match;
	logic        high_rst_match;
	logic        high_pwm;
	dbt_ctrl_t   wr_ctrl_val;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	assign wr_ctrl     = wr_en && (addr == DBT_ADDR_CONTROL);
	assign wr_presc    = wr_en && (addr == DBT_ADDR_PRESCALE_SEL);
	assign wr_lmatch   = wr_en && (addr == DBT_ADDR_LOW_MATCH);
	assign wr_hmatch   = wr_en && (addr == DBT_ADDR_HIGH_MATCH);
	assign wr_ctrl_val = dbt_ctrl_t'(wr_data);

	// Counters have no write path; unmapped reads return zero
	assign rd_mux =
		(addr == DBT_ADDR_CONTROL)      ? 8'(ctrl_q)  :
		(addr == DBT_ADDR_PRESCALE_SEL) ? 8'(presc_q) :
		(addr == DBT_ADDR_LOW_COUNT)    ? low_count   :
		(addr == DBT_ADDR_HIGH_COUNT)   ? high_count  :
		(addr == DBT_ADDR_LOW_MATCH)    ? low_match_q :
		(addr == DBT_ADDR_HIGH_MATCH)   ? high_match_q : DBT_READ_IDLE;

	// Flags: a write of 0 clears, a write of 1 keeps; a set in the
	// same cycle as the clear wins so no event is lost
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
		begin
			ctrl_d = wr_ctrl_val;
			ctrl_d.high_match_flag = ctrl_q.high_match_flag &
				wr_ctrl_val.high_match_flag;
			ctrl_d.low_match_flag = ctrl_q.low_match_flag &
				wr_ctrl_val.low_match_flag;
		end
		if (ctrl_q.high_run && high_ev.reach_zero)
			ctrl_d.high_match_flag = 1'b1;
		if (ctrl_q.low_run && low_ev.reach_zero)
			ctrl_d.low_match_flag = 1'b1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q       <= dbt_ctrl_t'(DBT_CONTROL_RST);
			presc_q      <= dbt_presc_t'(DBT_PRESCALE_RST);
			low_match_q  <= DBT_MATCH_RST;
			high_match_q <= DBT_MATCH_RST;
			rd_data_q    <= DBT_READ_IDLE;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			rd_data_q <= rd_en ? rd_mux : DBT_READ_IDLE;
			if (wr_presc)
				presc_q <= dbt_presc_t'(wr_data);
			if (wr_lmatch)
				low_match_q <= wr_data;
			if (wr_hmatch)
				high_match_q <= wr_data;
		end
	end

	// ------------------------------------------------------------
	// Count clock bases
	// ------------------------------------------------------------
	// Event pin passes two flops before the edge detector looks at it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			half_tick_q <= 1'b0;
			ev_s1_q     <= 1'b0;
			ev_s2_q     <= 1'b0;
			ev_s3_q     <= 1'b0;
		end
		else
		begin
			half_tick_q <= ~half_tick_q;
			ev_s1_q     <= event_in;
			ev_s2_q     <= ev_s1_q;
			ev_s3_q     <= ev_s2_q;
		end
	end

	assign event_pulse = ev_s2_q && !ev_s3_q;

	// PWM modes count every cycle; toggle modes every second cycle or
	// on external events, which the low half alone may use
	assign low_base = ctrl_q.output_mode_select ? 1'b1 :
		(low_event_sel ? event_pulse : half_tick_q);

	// Cascade feeds the high half from the low period: match in mode 2,
	// the full 256-count PWM overflow in mode 3
	assign high_base = !ctrl_q.cascade_select ?
		(ctrl_q.output_mode_select ? 1'b1 : half_tick_q) :
		(ctrl_q.output_mode_select ? low_ev.overflow_hit :
		low_ev.match_hit);

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	assign low_rst_match  = !ctrl_q.output_mode_select;
	assign high_rst_match = !(ctrl_q.output_mode_select &&
		!ctrl_q.cascade_select);
	assign high_pwm = ctrl_q.output_mode_select &&
		!ctrl_q.cascade_select;

	dbt_half u_low
	(
		.mclk           (mclk),
		.rst            (rst),
		.run            (ctrl_q.low_run),
		.base_tick      (low_base),
		.presc_enable   (presc_q.low_prescale_enable),
		.presc_code     (presc_q.low_prescale_code),
		.match_reg      (low_match_q),
		.reset_on_match (low_rst_match),
		.pwm_mode       (ctrl_q.output_mode_select),
		.count          (low_count),
		.events         (low_ev),
		.wave           (low_output)
	);

	dbt_half u_high
	(
		.mclk           (mclk),
		.rst            (rst),
		.run            (ctrl_q.high_run),
		.base_tick      (high_base),
		.presc_enable   (presc_q.high_prescale_enable),
		.presc_code     (presc_q.high_prescale_code),
		.match_reg      (high_match_q),
		.reset_on_match (high_rst_match),
		.pwm_mode       (high_pwm),
		.count          (high_count),
		.events         (high_ev),
		.wave           (high_output)
	);

	assign irq_req = (ctrl_q.high_irq_enable && ctrl_q.high_match_flag) ||
		(ctrl_q.low_irq_enable && ctrl_q.low_match_flag);
	assign rd_data = rd_data_q;
endmodule

// >>> dbt_timer_chk.sv
// Assertion checker for the dual byte timer register port and outputs
`timescale 1ns/1ps
module dbt_timer_chk
	import dbt_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [7:0]  rd_data,
	input wire logic        event_in,
	input wire logic        low_event_sel,
	input wire logic        high_output,
	input wire logic        low_output,
	input wire logic        irq_req
);
	// Shadow registers; flag bits are masked since hardware sets them
	logic [7:0] ctrl_q;
	logic [7:0] pre_q;
	logic [7:0] lm_q;
	logic [7:0] hm_q;
	wire        wr_ctrl = wr_en && addr == DBT_ADDR_CONTROL;
	wire        known   = addr == DBT_ADDR_PRESCALE_SEL
		|| addr == DBT_ADDR_LOW_MATCH || addr == DBT_ADDR_HIGH_MATCH
		|| addr < DBT_ADDR_CONTROL || addr > DBT_ADDR_HIGH_MATCH;
	wire  [7:0] exp_rd  = addr == DBT_ADDR_PRESCALE_SEL ? pre_q
		: addr == DBT_ADDR_LOW_MATCH ? lm_q
		: addr == DBT_ADDR_HIGH_MATCH ? hm_q : DBT_READ_IDLE;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= DBT_CONTROL_RST;
			pre_q  <= DBT_PRESCALE_RST;
			lm_q   <= DBT_MATCH_RST;
			hm_q   <= DBT_MATCH_RST;
		end
		else if (wr_en)
		begin
			ctrl_q <= addr == DBT_ADDR_CONTROL ? wr_data : ctrl_q;
			pre_q  <= addr == DBT_ADDR_PRESCALE_SEL ? wr_data : pre_q;
			lm_q   <= addr == DBT_ADDR_LOW_MATCH ? wr_data : lm_q;
			hm_q   <= addr == DBT_ADDR_HIGH_MATCH ? wr_data : hm_q;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	AST_RD_IDLE: assert property (rd_data != 8'h00 |-> $past(rd_en))
		else $error("read data outside read slot");
	AST_RD_REGS: assert property (rd_en && known |=> rd_data == $past(exp_rd))
		else $error("register read value wrong");
	AST_RD_CTRL: assert property (rd_en && addr == DBT_ADDR_CONTROL
		|=> (rd_data & 8'hf5) == ($past(ctrl_q) & 8'hf5))
		else $error("control read value wrong");
	AST_LCNT_STOP: assert property (rd_en && addr == DBT_ADDR_LOW_COUNT
		&& !ctrl_q[6] && $past(!ctrl_q[6]) |=> rd_data == 8'h00)
		else $error("stopped low counter not zero");
	AST_HCNT_STOP: assert property (rd_en && addr == DBT_ADDR_HIGH_COUNT
		&& !ctrl_q[7] && $past(!ctrl_q[7]) |=> rd_data == 8'h00)
		else $error("stopped high counter not zero");
	AST_LOUT_STOP: assert property ((!ctrl_q[6]) [*3] |-> low_output)
		else $error("low output not high while stopped");
	AST_HOUT_STOP: assert property ((!ctrl_q[7]) [*3] |-> high_output)
		else $error("high output not high while stopped");
	AST_LOUT_FF: assert property ((ctrl_q[6] && lm_q == 8'hff) [*3] |-> !low_output)
		else $error("low output not forced low");
	AST_IRQ_OFF: assert property (wr_ctrl && !wr_data[2] && !wr_data[0] |=> !irq_req)
		else $error("request with both enables off");
	AST_IRQ_EN: assert property (irq_req |-> ctrl_q[2] || ctrl_q[0])
		else $error("request without enable");

	cover property (wr_ctrl && wr_data[4]);
	cover property (irq_req);
	cover property ($rose(high_output) && ctrl_q[5]);
endmodule

bind dbt_timer dbt_timer_chk u_chk (.mclk, .rst, .addr, .wr_data, .wr_en,
	.rd_en, .rd_data, .event_in, .low_event_sel, .high_output, .low_output,
	.irq_req);

// >>> test_dual_byte_timer_pwm.sv
// Self-checking bench for the dual byte timer
`timescale 1ns/1ps
module test_dual_byte_timer_pwm
	import dbt_pkg::*;
;
	logic        mclk;
	logic        rst;
	logic [15:0] addr;
	logic [7:0]  wr_data;
	logic        wr_en;
	logic        rd_en;
	logic        event_in;
	logic        low_event_sel;
	logic [7:0]  rd_data;
	logic        high_output;
	logic        low_output;
	logic        irq_req;
	logic [7:0]  d;
	logic [15:0] lo;
	logic [15:0] per;
	int          bad_count;
	int          check_count;
	// Per row: control, prescale, matches, output watched, low time, period
	localparam logic [7:0]  TC [7] = '{8'h50, 8'h90, 8'h80, 8'h40, 8'he0, 8'hf0, 8'hf0};
	localparam logic [7:0]  TP [7] = '{8'h08, 8'h00, 8'h90, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0]  TL [7] = '{8'h03, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00, 8'h7f};
	localparam logic [7:0]  TH [7] = '{8'h00, 8'h10, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00};
	localparam logic        TS [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	localparam logic [15:0] TLO [7] = '{16'h0008, 16'h0011, 16'h0018, 16'h000a,
		16'h0008, 16'h0100, 16'h0080};
	localparam logic [15:0] TPER [7] = '{16'h0200, 16'h0100, 16'h0030, 16'h0014,
		16'h0010, 16'h0200, 16'h0100};

	dbt_timer DUT (.mclk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.event_in, .low_event_sel, .high_output, .low_output, .irq_req);

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task final_report;
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr    <= a;
		wr_data <= v;
		wr_en   <= 1'b1;
		@(posedge mclk);
		wr_en   <= 1'b0;
	endtask

	task rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		v = rd_data;
	endtask

	// Waits for a rising edge, then times one full cycle of the output
	task wave(input logic h, output logic [15:0] l, output logic [15:0] p);
		logic q;
		logic s;
		int   n;
		l = 16'h0000;
		p = 16'h0000;
		q = 1'b1;
		for (n = 0; n < 3000; n++)
		begin
			@(posedge mclk);
			#1;
			s = h ? high_output : low_output;
			if (s && !q)
				break;
			q = s;
		end
		q = 1'b1;
		for (n = 0; n < 3000; n++)
		begin
			@(posedge mclk);
			#1;
			s = h ? high_output : low_output;
			p++;
			if (!s)
				l++;
			if (s && !q)
				break;
			q = s;
		end
	endtask

	initial
	begin
		#1000000;
		bad_count++;
		final_report;
	end

	initial
	begin
		rst = 1'b1;
		addr = 16'h0000;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		event_in = 1'b0;
		low_event_sel = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk({high_output, low_output, irq_req}, 16'h0006);
		for (int i = 0; i < 7; i++)
		begin
			rd(DBT_ADDR_CONTROL + 16'(i), d);
			chk(d, 8'h00);
		end
		wr(DBT_ADDR_CONTROL, 8'h2f);
		rd(DBT_ADDR_CONTROL, d);
		chk(d, 8'h25);
		wr(DBT_ADDR_PRESCALE_SEL, 8'ha5);
		rd(DBT_ADDR_PRESCALE_SEL, d);
		chk(d, 8'ha5);
		wr(DBT_ADDR_LOW_COUNT, 8'h12);
		rd(DBT_ADDR_LOW_COUNT, d);
		chk(d, 8'h00);
		wr(DBT_ADDR_HIGH_COUNT, 8'h34);
		rd(DBT_ADDR_HIGH_COUNT, d);
		chk(d, 8'h00);
		for (int r = 0; r < 7; r++)
		begin
			wr(DBT_ADDR_CONTROL, 8'h00);
			wr(DBT_ADDR_PRESCALE_SEL, TP[r]);
			wr(DBT_ADDR_LOW_MATCH, TL[r]);
			wr(DBT_ADDR_HIGH_MATCH, TH[r]);
			wr(DBT_ADDR_CONTROL, TC[r]);
			wave(TS[r], lo, per);
			chk(lo, TLO[r]);
			chk(per, TPER[r]);
			// Stop with the flag bit written as 1 so the flag survives
			wr(DBT_ADDR_CONTROL, TS[r] ? 8'h0c : 8'h03);
			#1;
			chk(irq_req, 16'h0001);
			rd(TS[r] ? DBT_ADDR_HIGH_COUNT : DBT_ADDR_LOW_COUNT, d);
			chk(d, 8'h00);
			wr(DBT_ADDR_CONTROL, TS[r] ? 8'h04 : 8'h01);
			#1;
			chk(irq_req, 16'h0000);
		end
		wr(DBT_ADDR_LOW_MATCH, 8'hff);
		wr(DBT_ADDR_CONTROL, 8'h40);
		repeat (3) @(posedge mclk);
		#1;
		chk(low_output, 16'h0000);
		// Low half counting pin edges: match 1 toggles every second edge
		wr(DBT_ADDR_CONTROL, 8'h00);
		wr(DBT_ADDR_LOW_MATCH, 8'h01);
		low_event_sel <= 1'b1;
		wr(DBT_ADDR_CONTROL, 8'h40);
		for (int e = 0; e < 4; e++)
		begin
			@(posedge mclk);
			event_in <= 1'b1;
			repeat (4) @(posedge mclk);
			event_in <= 1'b0;
			repeat (4) @(posedge mclk);
			#1;
			chk(low_output, (e == 1 || e == 2) ? 16'h0000 : 16'h0001);
		end
		final_report;
	end
endmodule
